// File: eep_master_model.sv
// Purpose: Behavioural two-wire bus master that drives the serial clock.
// Assumes: Data wire is pulled up; level fed back through i_sda.
// Notes:   Clock idles high between frames; bit period is 8 system clocks.
`timescale 1ns/1ps
module eep_master_model (
    input  wire logic i_clock,    // System clock.
    input  wire logic i_sda,      // Resolved data wire level.
    output logic      o_scl = 1'b1,      // Serial clock.
    output logic      o_sda_oe_n = 1'b1  // Low pulls data low.
);
    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
    endtask

    // Data moves one clock after the clock fall so the slave sees hold time.
    task automatic start();
        tick(1);
        o_sda_oe_n <= 1'b1;
        tick(3);
        o_scl <= 1'b1;
        tick(2);
        o_sda_oe_n <= 1'b0;
        tick(2);
        o_scl <= 1'b0;
    endtask

    task automatic stop();
        tick(1);
        o_sda_oe_n <= 1'b0;
        tick(3);
        o_scl <= 1'b1;
        tick(2);
        o_sda_oe_n <= 1'b1;
        tick(4);
    endtask

    // Sampled late in the high phase, after the slave output has settled.
    task automatic xfer_bit(input logic b, output logic r);
        tick(1);
        o_sda_oe_n <= b;
        tick(3);
        o_scl <= 1'b1;
        tick(3);
        r = i_sda;
        tick(1);
        o_scl <= 1'b0;
    endtask

    task automatic send_byte(input logic [7:0] v, output logic acked);
        logic r;
        for (int i = 7; i >= 0; i--) xfer_bit(v[i], r);
        xfer_bit(1'b1, r);
        acked = (r === 1'b0);
    endtask

    task automatic recv_byte(input logic mack, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(1'b1, r);
            v[i] = r;
        end
        xfer_bit(~mack, r);
    endtask
endmodule

// File: eep_pkg.sv
// Purpose: Shared constants and types for the serial EEPROM access logic.
// Assumes: A 20 MHz system clock that oversamples the two-wire bus.
// Notes:   Shared widths, codes and timing counts live here.
package eep_pkg;

    // -------------------------------------------------------------------
    // Array and page geometry
    // -------------------------------------------------------------------
    localparam int ADDR_W     = 12;
    localparam int PAGE_W     = 5;
    localparam int MEM_DEPTH  = 4096;
    localparam int PAGE_BYTES = 32;
    localparam int CS_W       = 3;

    // -------------------------------------------------------------------
    // Device-address codes, serial-number region and bit-count codes
    // -------------------------------------------------------------------
    localparam logic [3:0] DEV_ARRAY  = 4'ha;
    localparam logic [3:0] DEV_SERIAL = 4'hb;
    localparam logic [1:0] SN_SELECT  = 2'h2;
    localparam logic [7:0] SN_BAD     = 8'hff;
    localparam logic [7:0] SN_FILL    = 8'h00;
    localparam logic [3:0] BIT_ACK    = 4'h8;
    localparam logic [3:0] BIT_MACK   = 4'h9;

    // -------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------
    localparam int CLK_HZ    = 20_000_000;
    localparam int T_WR_MS   = 5;
    localparam int TWR_CYC   = T_WR_MS * (CLK_HZ / 1000);

    // -------------------------------------------------------------------
    // Protocol states
    // -------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEV,
        ST_HI,
        ST_LO,
        ST_WDATA,
        ST_RDATA
    } eep_state_t;

endpackage

// File: eep_serial_eeprom.sv
// Purpose: Two-wire serial EEPROM slave with a 4,096-byte array and a
//          read-only serial-number block.
// Assumes: SCL and SDA arrive asynchronously and are oversampled.
// Notes:   Array contents are not reset; the pointer survives transactions.
// Notes on behaviour
// - Byte write: device address, two address bytes, one data byte, acked.
// - Stop after array write data starts timed programming; inputs then ignored.
// - Page write continues after first byte, up to 32 bytes per page.
// - Every received page-write data byte is acknowledged low.
// - Write address increments only its low five bits.
// - Passing page end wraps to the page start, overwriting earlier bytes.
// - No acknowledge of the device address while programming runs.
// - Read uses the same device address with direction bit one.
// - Pointer holds last accessed location plus one across transactions.
// - Read pointer wraps from the last array byte to the first.
// - Current-address read sends byte at pointer; master nacks and stops.
// - Master ack gives next byte with wrap; nack plus Stop ends.
// - Array and serial block share one pointer; dummy write positions it.
// - Current-address serial read continues from the shared pointer.
// - Serial block needs top address bits 10, else undefined data.
// - Sixteen serial bytes, sixteen zero bytes, then wrap to serial start.
// - Array device address is 1010, chip-select bits, direction bit.
// - Serial device address is 1011 with the same chip-select compare.
// - Each received byte after a matching device address is acknowledged low during the ninth clock.
// - Chip-select mismatch gives no acknowledge and returns to idle.
`timescale 1ns/1ps
module eep_serial_eeprom #(
    parameter int unsigned   PROG_CYCLES   = eep_pkg::TWR_CYC,
    parameter logic [127:0]  SERIAL_NUMBER = // Default value is arbitrary.
        128'h0123456789abcdef0f1e2d3c4b5a6978
) (
    input  wire logic                    i_clock,            // System clock.
    input  wire logic                    i_sys_rst,          // Sync reset.
    input  wire logic                    i_scl,              // Serial clock pin.
    input  wire logic                    i_sda,              // Data pin level.
    input  wire logic [eep_pkg::CS_W-1:0] i_chip_select_pins, // Strap pins.
    output logic                         o_sda_out,          // Data drive value.
    output logic                         o_sda_oe_n,         // Low drives data.
    output logic                         o_busy              // Programming.
);
    import eep_pkg::*;
    default clocking a_cb @(posedge i_clock);
    endclocking
    default disable iff (i_sys_rst);

    // -------------------------------------------------------------------
    // Input synchronisers and bus condition detection
    // -------------------------------------------------------------------
    logic            scl_m_q, scl_s_q, scl_p_q;
    logic            sda_m_q, sda_s_q, sda_p_q;
    logic [CS_W-1:0] cs_m_q, cs_s_q;

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
            sda_p_q <= 1'b1;
            cs_m_q  <= '0;
            cs_s_q  <= '0;
        end else begin
            scl_m_q <= i_scl;
            scl_s_q <= scl_m_q;
            scl_p_q <= scl_s_q;
            sda_m_q <= i_sda;
            sda_s_q <= sda_m_q;
            sda_p_q <= sda_s_q;
            cs_m_q  <= i_chip_select_pins;
            cs_s_q  <= cs_m_q;
        end
    end

    logic scl_rise, scl_fall, bus_start, bus_stop;
    assign scl_rise  = scl_s_q & ~scl_p_q;
    assign scl_fall  = ~scl_s_q & scl_p_q;
    assign bus_start = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
    assign bus_stop  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

    // -------------------------------------------------------------------
    // Storage, pointer and state
    // -------------------------------------------------------------------
    logic [7:0]            mem [MEM_DEPTH];
    logic [7:0]            page_buf [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] page_mask_q;
    logic [ADDR_W-1:0]     addr_q;
    logic [ADDR_W-PAGE_W-1:0] prog_row_q;
    eep_state_t            state_q;
    logic [3:0]            bit_cnt_q;
    logic [7:0]            shift_q, out_q;
    logic                  ack_q, mack_q, sn_q, rd_q, busy_q, sda_out_q;
    logic [31:0]           busy_cnt_q;

    logic       rx_state, byte_done, dev_hit, ev_wbyte, ev_rload;
    logic [7:0] rd_byte;
    assign rx_state  = (state_q == ST_DEV) || (state_q == ST_HI) ||
                       (state_q == ST_LO) || (state_q == ST_WDATA);
    assign byte_done = scl_fall && rx_state && !ack_q && bit_cnt_q == BIT_ACK;
    assign dev_hit   = (shift_q[7:4] == DEV_ARRAY ||
                        shift_q[7:4] == DEV_SERIAL) &&
                       shift_q[3:1] == cs_s_q;
    assign ev_wbyte  = byte_done && state_q == ST_WDATA && !sn_q;
    assign ev_rload  = scl_fall && ((ack_q && state_q == ST_DEV && rd_q) ||
                       (state_q == ST_RDATA && bit_cnt_q == BIT_MACK &&
                        mack_q));

    always_comb begin
        rd_byte = mem[addr_q];
        if (sn_q) begin
            if (addr_q[ADDR_W-1 -: 2] != SN_SELECT) begin
                rd_byte = SN_BAD;
            end else if (addr_q[PAGE_W-1]) begin
                rd_byte = SN_FILL;
            end else begin
                rd_byte = SERIAL_NUMBER[{~addr_q[3:0], 3'h0} +: 8];
            end
        end
    end

    // -------------------------------------------------------------------
    // Protocol engine
    // -------------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            state_q    <= ST_IDLE;
            bit_cnt_q  <= '0;
            shift_q    <= '0;
            out_q      <= '0;
            ack_q      <= 1'b0;
            mack_q     <= 1'b0;
            sn_q       <= 1'b0;
            rd_q       <= 1'b0;
            o_sda_oe_n <= 1'b1;
        end else if (busy_q) begin
            state_q    <= ST_IDLE;
            o_sda_oe_n <= 1'b1;
        end else if (bus_start) begin
            state_q    <= ST_DEV;
            bit_cnt_q  <= '0;
            ack_q      <= 1'b0;
            o_sda_oe_n <= 1'b1;
        end else if (bus_stop) begin
            state_q    <= ST_IDLE;
            o_sda_oe_n <= 1'b1;
        end else if (scl_rise) begin
            if (rx_state && bit_cnt_q < BIT_ACK && !ack_q) begin
                shift_q   <= {shift_q[6:0], sda_s_q};
                bit_cnt_q <= bit_cnt_q + 4'h1;
            end else if (state_q == ST_RDATA && bit_cnt_q < BIT_ACK) begin
                bit_cnt_q <= bit_cnt_q + 4'h1;
            end else if (state_q == ST_RDATA && bit_cnt_q == BIT_ACK) begin
                mack_q    <= ~sda_s_q;
                bit_cnt_q <= BIT_MACK;
            end
        end else if (scl_fall) begin
            if (byte_done) begin
                if (state_q == ST_DEV) begin
                    if (dev_hit) begin
                        ack_q      <= 1'b1;
                        o_sda_oe_n <= 1'b0;
                        sn_q       <= (shift_q[7:4] == DEV_SERIAL);
                        rd_q       <= shift_q[0];
                    end else begin
                        state_q <= ST_IDLE;
                    end
                end else begin
                    ack_q      <= 1'b1;
                    o_sda_oe_n <= 1'b0;
                end
            end else if (ack_q) begin
                ack_q      <= 1'b0;
                bit_cnt_q  <= '0;
                o_sda_oe_n <= 1'b1;
                case (state_q)
                    ST_DEV: begin
                        state_q <= rd_q ? ST_RDATA : ST_HI;
                        if (rd_q) begin
                            out_q      <= rd_byte;
                            o_sda_oe_n <= rd_byte[7];
                        end
                    end
                    ST_HI:   state_q <= ST_LO;
                    ST_LO:   state_q <= ST_WDATA;
                    default: state_q <= state_q;
                endcase
            end else if (state_q == ST_RDATA) begin
                if (bit_cnt_q < BIT_ACK) begin
                    o_sda_oe_n <= out_q[3'h7 - bit_cnt_q[2:0]];
                end else if (bit_cnt_q == BIT_ACK) begin
                    o_sda_oe_n <= 1'b1;
                end else if (mack_q) begin
                    out_q      <= rd_byte;
                    o_sda_oe_n <= rd_byte[7];
                    bit_cnt_q  <= '0;
                end else begin
                    state_q <= ST_IDLE;
                end
            end
        end
    end

    // -------------------------------------------------------------------
    // Address pointer and page buffer
    // -------------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            addr_q      <= '0;
            page_mask_q <= '0;
        end else if (!busy_q) begin
            if (byte_done && state_q == ST_DEV) begin
                page_mask_q <= '0;
            end else if (byte_done && state_q == ST_HI) begin
                // shared pointer loaded by dummy write
                addr_q[ADDR_W-1:8] <= shift_q[ADDR_W-9:0];
            end else if (byte_done && state_q == ST_LO) begin
                addr_q[7:0] <= shift_q;
            end else if (ev_wbyte) begin
                page_buf[addr_q[PAGE_W-1:0]]    <= shift_q;
                page_mask_q[addr_q[PAGE_W-1:0]] <= 1'b1;
                addr_q[PAGE_W-1:0] <= addr_q[PAGE_W-1:0] + 5'h01;
            end else if (ev_rload) begin
                // pointer is last read plus one
                if (sn_q) begin
                    addr_q[PAGE_W-1:0] <= addr_q[PAGE_W-1:0] + 5'h01;
                end else begin
                    addr_q <= addr_q + 12'h001;
                end
            end
        end
    end

    // -------------------------------------------------------------------
    // Timed programming cycle
    // -------------------------------------------------------------------
    logic prog_go;
    assign prog_go = !busy_q && bus_stop && state_q == ST_WDATA &&
                     !sn_q && page_mask_q != '0;

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            busy_q     <= 1'b0;
            busy_cnt_q <= '0;
            prog_row_q <= '0;
        end else if (prog_go) begin
            busy_q     <= 1'b1;
            busy_cnt_q <= '0;
            prog_row_q <= addr_q[ADDR_W-1:PAGE_W];
        end else if (busy_q) begin
            busy_cnt_q <= busy_cnt_q + 32'h1;
            if (busy_cnt_q == PROG_CYCLES - 1) begin
                busy_q <= 1'b0;
            end
        end
    end

    // page bytes written into their own row
    always_ff @(posedge i_clock) begin
        if (busy_q && busy_cnt_q < PAGE_BYTES &&
            page_mask_q[busy_cnt_q[PAGE_W-1:0]]) begin
            mem[{prog_row_q, busy_cnt_q[PAGE_W-1:0]}] <=
                page_buf[busy_cnt_q[PAGE_W-1:0]];
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            sda_out_q <= 1'b0;
            o_busy    <= 1'b0;
        end else begin
            sda_out_q <= 1'b0;
            o_busy    <= busy_q;
        end
    end
    assign o_sda_out = sda_out_q;

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    sequence seq_write_stop;
        !busy_q && bus_stop && state_q == ST_WDATA && !sn_q &&
            page_mask_q != '0;
    endsequence

    a_prog_on_stop: assert property (seq_write_stop |=> busy_q [*8])
        else $error("no programming after stop");
    a_busy_silent: assert property (
        busy_q |=> o_sda_oe_n && state_q == ST_IDLE)
        else $error("device drove data while busy");
    a_busy_ends: assert property (
        busy_q && busy_cnt_q == PROG_CYCLES - 1 |=> !busy_q)
        else $error("programming length wrong");
    a_page_wrap: assert property (
        ev_wbyte |=> addr_q[11:5] == $past(addr_q[11:5]) &&
            addr_q[4:0] == $past(addr_q[4:0]) + 5'h01)
        else $error("write pointer left its page");
    a_read_wrap: assert property (
        ev_rload && !sn_q && addr_q == 12'hfff |=> addr_q == 12'h000)
        else $error("read pointer did not wrap");
    a_cs_reject: assert property (
        byte_done && state_q == ST_DEV && !dev_hit |=>
            state_q == ST_IDLE && o_sda_oe_n)
        else $error("mismatched address acknowledged");
    a_ack_low: assert property (
        byte_done && (state_q != ST_DEV || dev_hit) |=> !o_sda_oe_n && ack_q)
        else $error("received byte not acknowledged");
    a_sn_zero: assert property (
        ev_rload && sn_q && addr_q[11:10] == SN_SELECT && addr_q[4] |=>
            out_q == SN_FILL)
        else $error("serial fill byte not zero");
    a_sn_no_write: assert property (
        bus_stop && sn_q && !busy_q |=> !busy_q)
        else $error("serial block write started programming");

endmodule

// File: eep_serial_eeprom_bench.sv
// Purpose: Self-checking bench for the serial EEPROM access logic.
// Assumes: Programming count shortened to 200 clocks.
// Notes:   Reference model tracks array bytes and the shared pointer.
`timescale 1ns/1ps
module eep_serial_eeprom_bench;
    import eep_pkg::*;
    localparam int unsigned  PROG = 200;
    localparam logic [127:0] SN   = 128'h5a17c3e90b6d248f7e11a0c4d93b6f25;

    logic       clock   = 1'b0;
    logic       sys_rst = 1'b1;
    logic [2:0] cs      = 3'h5;
    logic       scl;
    logic       m_oe_n;
    logic       d_out;
    logic       d_oe_n;
    logic       busy;
    wire logic  sda;
    int         mem[int];
    int         ptr;
    int         n_fail;
    int         n_compared;
    int         busy_cnt;
    integer     seed = 27;

    assign sda = ~(~m_oe_n | (~d_oe_n & ~d_out));
    always #25 clock = ~clock;
    always @(posedge clock) if (busy) busy_cnt <= busy_cnt + 1;

    eep_master_model mst (.i_clock(clock), .i_sda(sda), .o_scl(scl),
                          .o_sda_oe_n(m_oe_n));
    eep_serial_eeprom #(.PROG_CYCLES(PROG), .SERIAL_NUMBER(SN)) dut (
        .i_clock(clock), .i_sys_rst(sys_rst), .i_scl(scl), .i_sda(sda),
        .i_chip_select_pins(cs), .o_sda_out(d_out), .o_sda_oe_n(d_oe_n),
        .o_busy(busy));

    task automatic tally_and_finish();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input int exp, input string w);
        n_compared++;
        if (got !== exp[7:0]) begin
            n_fail++;
            $display("FAIL %0t %s got %h exp %h", $time, w, got, exp[7:0]);
        end
    endtask

    task automatic wr(input logic [3:0] pre, input int a, input int n);
        logic       k;
        logic [7:0] d;
        mst.start();
        mst.send_byte({pre, cs, 1'b0}, k);
        check(8'(k), 1, "dev ack");
        mst.send_byte(8'(a >> 8), k);
        check(8'(k), 1, "hi ack");
        mst.send_byte(8'(a), k);
        check(8'(k), 1, "lo ack");
        ptr = a & 'hfff;
        for (int i = 0; i < n; i++) begin
            d = 8'($random(seed));
            mst.send_byte(d, k);
            check(8'(k), 1, "data ack");
            if (pre == DEV_ARRAY) mem[ptr] = d;
            ptr = (ptr & 'hfe0) | ((ptr + 1) & 'h1f);
        end
    endtask

    task automatic rd(input logic [3:0] pre, input int n);
        logic       k;
        logic [7:0] d;
        int         e;
        mst.start();
        mst.send_byte({pre, cs, 1'b1}, k);
        check(8'(k), 1, "read ack");
        for (int i = 0; i < n; i++) begin
            mst.recv_byte(i < n - 1, d);
            if (pre == DEV_SERIAL)
                e = (ptr[11:10] != 2'h2) ? 'hff :
                    ptr[4] ? 0 : SN[127 - 8 * ptr[3:0] -: 8];
            else
                e = mem.exists(ptr) ? mem[ptr] : -1;
            if (e >= 0) check(d, e, "read data");
            ptr = (pre == DEV_SERIAL) ? ((ptr & 'hfe0) | ((ptr + 1) & 'h1f))
                                      : ((ptr + 1) & 'hfff);
        end
        mst.stop();
    endtask

    task automatic program_wait();
        logic k;
        int   tries;
        int   b0;
        b0    = busy_cnt;
        k     = 1'b0;
        tries = 0;
        mst.stop();
        while (!k && tries < 20) begin
            mst.start();
            mst.send_byte({DEV_ARRAY, cs, 1'b0}, k);
            if (tries == 0) check(8'(k), 0, "poll nack");
            tries++;
        end
        mst.stop();
        check(8'(k), 1, "poll ack");
        check(8'(busy_cnt - b0), PROG, "busy length");
    endtask

    initial begin
        repeat (100000) @(posedge clock);
        n_fail++;
        $display("FAIL %0t watchdog expired", $time);
        tally_and_finish();
    end

    initial begin
        logic k;
        int   b0;
        cs <= 3'($random(seed));
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clock);
        mst.start();
        mst.send_byte({DEV_ARRAY, cs ^ 3'h1, 1'b0}, k);
        check(8'(k), 0, "cs mismatch");
        mst.start();
        mst.send_byte({4'h9, cs, 1'b1}, k);
        check(8'(k), 0, "foreign nibble");
        mst.stop();
        wr(DEV_ARRAY, 'hffe, 2);
        program_wait();
        wr(DEV_ARRAY, 'h000, 1);
        program_wait();
        wr(DEV_ARRAY, 'h3e5, 34);
        program_wait();
        rd(DEV_ARRAY, 1);
        wr(DEV_ARRAY, 'hffe, 0);
        rd(DEV_ARRAY, 4);
        wr(DEV_ARRAY, 'h3e0, 0);
        rd(DEV_ARRAY, 32);
        wr(DEV_SERIAL, 'h80e, 0);
        rd(DEV_SERIAL, 20);
        wr(DEV_SERIAL, 'h800, 0);
        rd(DEV_SERIAL, 16);
        wr(DEV_SERIAL, 'h400, 0);
        rd(DEV_SERIAL, 1);
        b0 = busy_cnt;
        wr(DEV_SERIAL, 'h800, 3);
        mst.stop();
        repeat (20) @(posedge clock);
        check(8'(busy_cnt - b0), 0, "serial write busy");
        wr(DEV_SERIAL, 'h800, 0);
        rd(DEV_SERIAL, 4);
        wr(DEV_ARRAY, 'h805, 0);
        mst.stop();
        rd(DEV_SERIAL, 2);
        tally_and_finish();
    end
endmodule
